// [pkg/mac_cfg.svh]
// Register map, field positions and reset values of the MAC unit
`ifndef MAC_CFG_SVH
`define MAC_CFG_SVH

// ----------------------------------------------------------------
// Register indices, byte address = 4 x index
// ----------------------------------------------------------------
`define MAC_IDX_CTRL 3'h0
`define MAC_IDX_OPA 3'h1
`define MAC_IDX_OPB 3'h2
`define MAC_IDX_ACCH 3'h3
`define MAC_IDX_ACCM 3'h4
`define MAC_IDX_ACCL 3'h5
`define MAC_IDX_STAT 3'h6
`define MAC_IDX_MASK 3'h7

// ----------------------------------------------------------------
// Bus address layout
// ----------------------------------------------------------------
`define MAC_ADR_W 8
`define MAC_IDX_HI 4
`define MAC_IDX_LO 2
`define MAC_ADR_TOP_HI 7
`define MAC_ADR_TOP_LO 5
`define MAC_ADR_TOP_ZERO 3'h0
`define MAC_ADR_LOW_ZERO 2'h0

// ----------------------------------------------------------------
// Control word fields
// ----------------------------------------------------------------
`define MAC_B_SGN 0
`define MAC_B_ACC 1
`define MAC_B_SUB 2
`define MAC_B_ONE 3
`define MAC_B_SQU 4
`define MAC_B_CLD 5
`define MAC_B_INH 6
`define MAC_B_OVF 7
`define MAC_B_DIV 8
`define MAC_CTRL_STORE 16'h015f

// ----------------------------------------------------------------
// Interrupt status and mask fields
// ----------------------------------------------------------------
`define MAC_IRQ_W 2
`define MAC_IRQ_DONE 0
`define MAC_IRQ_OVF 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MAC_RST16 16'h0000
`define MAC_RST48 48'h000000000000
`define MAC_RST32 32'h00000000
`define MAC_RST_IRQ 2'h0

`endif

// [pkg/mac_pkg.sv]
// Types shared by the MAC unit modules
package mac_pkg;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MAC_IDLE = 2'b01,
    MAC_RUN = 2'b10
  } mac_state_t;

endpackage

// [pkg/mac_if.sv]
// Link between the MAC register block and its arithmetic core
`timescale 1ns/1ps
`default_nettype none

interface mac_if;
  logic start;
  logic abort;
  logic sgn;
  logic accm;
  logic sub;
  logic [15:0] opa;
  logic [15:0] opb;
  logic [47:0] acc;
  logic [47:0] result;
  logic ovf;
  logic done;

  modport host (
    output start, abort, sgn, accm, sub, opa, opb, acc,
    input result, ovf, done
  );

  modport unit (
    input start, abort, sgn, accm, sub, opa, opb, acc,
    output result, ovf, done
  );
endinterface

`default_nettype wire

// [src/mac_core.sv]
// Arithmetic core: one multiply with add, subtract or negate
`timescale 1ns/1ps
`default_nettype none
`include "mac_cfg.svh"

module mac_core
  import mac_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Link to the register block
  mac_if.unit lnk
);

  logic [16:0] a_x;
  logic [16:0] b_x;
  logic signed [33:0] prod;
  logic [49:0] prod_x;
  logic [49:0] acc_x;
  logic [49:0] base;
  logic [49:0] sum;
  logic ovf_next;
  logic [47:0] result_reg;
  logic ovf_reg;
  logic done_reg;

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  always_comb begin
    a_x = {lnk.sgn & lnk.opa[15], lnk.opa};
    b_x = {lnk.sgn & lnk.opb[15], lnk.opb};
    prod = $signed(a_x) * $signed(b_x);
    prod_x = {{16{prod[33]}}, prod};
    // Sign of the whole accumulator sits in the high word
    acc_x = {{2{lnk.sgn & lnk.acc[47]}}, lnk.acc};
    base = lnk.accm ? acc_x : 50'h0;
    sum = lnk.sub ? (base - prod_x) : (base + prod_x);
    // Two guard bits catch both signed and unsigned range loss
    if (lnk.sgn) begin
      ovf_next = (sum[49] != sum[48]) || (sum[48] != sum[47]);
    end else begin
      ovf_next = (sum[49:48] != 2'h0);
    end
  end

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      result_reg <= `MAC_RST48;
      ovf_reg <= 1'b0;
    end else if (lnk.start && !lnk.abort) begin
      result_reg <= sum[47:0];
      ovf_reg <= ovf_next;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= lnk.start && !lnk.abort;
    end
  end

  assign lnk.result = result_reg;
  assign lnk.ovf = ovf_reg;
  assign lnk.done = done_reg;

endmodule

`default_nettype wire

// [src/mac_top.sv]
// MAC unit: Wishbone register block, trigger logic and accumulator
//
// What this block does
// - Inhibit bit 0 writes results to accumulator; 1 leaves it unchanged.
// - Inhibit control is control bit 6; it never affects division.
// - Overflow flag, control bit 7, reads 1 after an overflowing op.
// - Overflow flag clears on reset, operation start and clear-all-data.
// - Control bits 15 to 9 always read as zero.
// - Operands A and B are freely readable and writable 16-bit words.
// - Loading operands starts the chosen op; result goes to accumulator.
// - Operands are signed or unsigned as the signed-select bit says.
// - Accumulator is 48 bits in three words; high word is bytes 5,4.
// - In signed mode accumulator bit 47 is the sign.
// - Operands and high accumulator word reset to zero, free access.
// - Single trigger 0 needs both operands written; 1 starts on either.
// - Square enable: either write loads both operands, starts a square.
// - Clear strobe zeroes data, flag, sequence; aborts; self-clears.
// - Middle word is bytes 3,2; low word bytes 1,0; both reset zero.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mac_cfg.svh"

module mac_top
  import mac_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`MAC_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Interrupt
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] mac_merge(
    input logic [15:0] old_val,
    input logic [15:0] new_val,
    input logic [3:0] sel
  );
    logic [15:0] r;
    r = old_val;
    if (sel[0]) begin
      r[7:0] = new_val[7:0];
    end
    if (sel[1]) begin
      r[15:8] = new_val[15:8];
    end
    return r;
  endfunction

  function automatic logic mac_hit(
    input logic acc_ok,
    input logic [2:0] idx,
    input logic [2:0] want
  );
    return acc_ok && (idx == want);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  mac_if lnk ();

  mac_state_t state_reg;
  mac_state_t state_next;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [15:0] ctrl_reg;
  logic ovf_flag_reg;
  logic [15:0] opa_reg;
  logic [15:0] opb_reg;
  logic [47:0] acc_reg;
  logic a_seen_reg;
  logic b_seen_reg;
  logic [`MAC_IRQ_W-1:0] stat_reg;
  logic [`MAC_IRQ_W-1:0] mask_reg;

  logic req;
  logic adr_ok;
  logic [2:0] idx;
  logic wr;
  logic rd;
  logic [15:0] wdat;
  logic wr_ctrl;
  logic wr_a;
  logic wr_b;
  logic wr_acch;
  logic wr_accm;
  logic wr_accl;
  logic wr_stat;
  logic wr_mask;
  logic clear_all_data;
  logic square;
  logic single;
  logic trigger;
  logic done_ok;
  logic [15:0] opa_w;
  logic [15:0] opb_w;
  logic [15:0] ctrl_view;
  logic [15:0] rd_word;
  logic [`MAC_IRQ_W-1:0] stat_set;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Ack one cycle after the request; the one-cycle gap keeps it
  // from being mistaken for a second request
  assign req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr = req && wb_we_i;
  assign rd = req && !wb_we_i;
  assign idx = wb_adr_i[`MAC_IDX_HI:`MAC_IDX_LO];
  assign adr_ok =
    (wb_adr_i[`MAC_ADR_TOP_HI:`MAC_ADR_TOP_LO] == `MAC_ADR_TOP_ZERO)
    && (wb_adr_i[1:0] == `MAC_ADR_LOW_ZERO);
  assign wdat = wb_dat_i[15:0];

  assign wr_ctrl = mac_hit(wr && adr_ok, idx, `MAC_IDX_CTRL);
  assign wr_a = mac_hit(wr && adr_ok, idx, `MAC_IDX_OPA);
  assign wr_b = mac_hit(wr && adr_ok, idx, `MAC_IDX_OPB);
  assign wr_acch = mac_hit(wr && adr_ok, idx, `MAC_IDX_ACCH);
  assign wr_accm = mac_hit(wr && adr_ok, idx, `MAC_IDX_ACCM);
  assign wr_accl = mac_hit(wr && adr_ok, idx, `MAC_IDX_ACCL);
  assign wr_stat = mac_hit(wr && adr_ok, idx, `MAC_IDX_STAT);
  assign wr_mask = mac_hit(wr && adr_ok, idx, `MAC_IDX_MASK);

  // Clear-all-data is a strobe; it is never stored
  assign clear_all_data = wr_ctrl && wb_sel_i[0] && wdat[`MAC_B_CLD];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  // ----------------------------------------------------------------
  // Trigger logic
  // ----------------------------------------------------------------
  assign square = ctrl_reg[`MAC_B_SQU];
  assign single = ctrl_reg[`MAC_B_ONE];
  assign opa_w = mac_merge(opa_reg, wdat, wb_sel_i);
  assign opb_w = mac_merge(opb_reg, wdat, wb_sel_i);

  always_comb begin
    if (clear_all_data) begin
      trigger = 1'b0;
    end else if (square || single) begin
      trigger = wr_a || wr_b;
    end else begin
      trigger = (wr_a && b_seen_reg) || (wr_b && a_seen_reg);
    end
  end

  // Sequence counter: which operand has arrived since the last start
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      a_seen_reg <= 1'b0;
      b_seen_reg <= 1'b0;
    end else if (clear_all_data || trigger) begin
      a_seen_reg <= 1'b0;
      b_seen_reg <= 1'b0;
    end else begin
      if (wr_a) begin
        a_seen_reg <= 1'b1;
      end
      if (wr_b) begin
        b_seen_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    case (state_reg)
      MAC_IDLE: begin
        state_next = trigger ? MAC_RUN : MAC_IDLE;
      end
      MAC_RUN: begin
        state_next = MAC_IDLE;
      end
      default: begin
        state_next = MAC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= MAC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign lnk.start = (state_reg == MAC_RUN);
  assign lnk.abort = clear_all_data;
  assign lnk.sgn = ctrl_reg[`MAC_B_SGN];
  assign lnk.accm = ctrl_reg[`MAC_B_ACC];
  assign lnk.sub = ctrl_reg[`MAC_B_SUB];
  assign lnk.opa = opa_reg;
  assign lnk.opb = opb_reg;
  assign lnk.acc = acc_reg;

  // Divide enable is kept only as a stored bit; no divider exists
  mac_core u_core (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .lnk(lnk)
  );

  assign done_ok = lnk.done && !clear_all_data;

  // ----------------------------------------------------------------
  // Control word
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= `MAC_RST16;
    end else if (wr_ctrl) begin
      ctrl_reg <= mac_merge(ctrl_reg, wdat, wb_sel_i)
        & `MAC_CTRL_STORE;
    end
  end

  // A finishing result wins over a start in the same edge
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ovf_flag_reg <= 1'b0;
    end else if (clear_all_data) begin
      ovf_flag_reg <= 1'b0;
    end else if (done_ok) begin
      ovf_flag_reg <= lnk.ovf;
    end else if (trigger) begin
      ovf_flag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Operand registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      opa_reg <= `MAC_RST16;
    end else if (clear_all_data) begin
      opa_reg <= `MAC_RST16;
    end else if (wr_a) begin
      opa_reg <= opa_w;
    end else if (wr_b && square) begin
      opa_reg <= opb_w;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      opb_reg <= `MAC_RST16;
    end else if (clear_all_data) begin
      opb_reg <= `MAC_RST16;
    end else if (wr_b) begin
      opb_reg <= opb_w;
    end else if (wr_a && square) begin
      opb_reg <= opa_w;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------
  // Hardware result wins over a software word write in the same edge
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      acc_reg <= `MAC_RST48;
    end else if (clear_all_data) begin
      acc_reg <= `MAC_RST48;
    end else if (done_ok) begin
      if (!ctrl_reg[`MAC_B_INH]) begin
        acc_reg <= lnk.result;
      end
    end else if (wr_acch) begin
      acc_reg[47:32] <= mac_merge(acc_reg[47:32], wdat, wb_sel_i);
    end else if (wr_accm) begin
      acc_reg[31:16] <= mac_merge(acc_reg[31:16], wdat, wb_sel_i);
    end else if (wr_accl) begin
      acc_reg[15:0] <= mac_merge(acc_reg[15:0], wdat, wb_sel_i);
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign stat_set = {done_ok && lnk.ovf, done_ok};

  // Write one to clear; a new event in the same edge still sets
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stat_reg <= `MAC_RST_IRQ;
    end else if (wr_stat && wb_sel_i[0]) begin
      stat_reg <= (stat_reg & ~wdat[`MAC_IRQ_W-1:0]) | stat_set;
    end else begin
      stat_reg <= stat_reg | stat_set;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mask_reg <= `MAC_RST_IRQ;
    end else if (wr_mask && wb_sel_i[0]) begin
      mask_reg <= wdat[`MAC_IRQ_W-1:0];
    end
  end

  assign irq_o = |(stat_reg & mask_reg);

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_view = ctrl_reg & `MAC_CTRL_STORE;
    ctrl_view[`MAC_B_OVF] = ovf_flag_reg;
  end

  always_comb begin
    rd_word = `MAC_RST16;
    if (adr_ok) begin
      case (idx)
        `MAC_IDX_CTRL: begin
          rd_word = ctrl_view;
        end
        `MAC_IDX_OPA: begin
          rd_word = opa_reg;
        end
        `MAC_IDX_OPB: begin
          rd_word = opb_reg;
        end
        `MAC_IDX_ACCH: begin
          rd_word = acc_reg[47:32];
        end
        `MAC_IDX_ACCM: begin
          rd_word = acc_reg[31:16];
        end
        `MAC_IDX_ACCL: begin
          rd_word = acc_reg[15:0];
        end
        `MAC_IDX_STAT: begin
          rd_word = {14'h0, stat_reg};
        end
        `MAC_IDX_MASK: begin
          rd_word = {14'h0, mask_reg};
        end
        default: begin
          rd_word = `MAC_RST16;
        end
      endcase
    end
  end

  // Unmapped addresses still ack, reading zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dat_reg <= `MAC_RST32;
    end else if (rd) begin
      dat_reg <= {16'h0, rd_word};
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

endmodule

`default_nettype wire

// [test/mac_top_asserts.sv]
// Concurrent checks on the MAC unit bus and interrupt ports
`timescale 1ns/1ps
`default_nettype none
`include "mac_cfg.svh"
module mac_top_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Wishbone slave and interrupt
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`MAC_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // Bus steps
  // ----------------------------------------------------------------
  sequence take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence rd_take;
    take ##0 !wb_we_i;
  endsequence
  sequence rd_ctrl;
    rd_take ##0 wb_adr_i == 8'h00;
  endsequence
  sequence rd_bad;
    rd_take ##0 wb_adr_i[1:0] != 2'h0;
  endsequence
  ack_timing_a: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle after request");
  ack_cause_a: assert property (
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  ack_idle_a: assert property (!wb_ack_o && !wb_stb_i |=> !wb_ack_o)
    else $error("ack while idle");
  dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
    else $error("upper read data not zero");
  dat_stand_a: assert property (
    !(wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i)
    |=> $stable(wb_dat_o))
    else $error("read data changed without read");
  ctrl_reserved_a: assert property (
    rd_ctrl |=> !wb_dat_o[5] && wb_dat_o[15:9] == 7'h0)
    else $error("control reserved bits not zero");
  unmapped_zero_a: assert property (
    rd_bad |=> wb_ack_o && wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  reset_quiet_a: assert property (
    $rose(rst_b) |-> !wb_ack_o && !irq_o && wb_dat_o == 32'h0)
    else $error("outputs not quiet after reset");
endmodule
`default_nettype wire

// [test/mac_cpu_model.sv]
// Processor core model: classic Wishbone master
`timescale 1ns/1ps
`default_nettype none
module mac_cpu_model (
  // Clock
  input wire logic clk_sys,
  // Bus master
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic wb_ack_i,
  input wire logic [31:0] wb_dat_i
);
  logic hung = 1'b0;
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end
  // Called just after a rising edge; request held until ack seen or 50 edges pass
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= w;
    wb_adr_o <= a;
    wb_sel_o <= s;
    wb_dat_o <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!wb_ack_i && n < 50);
    // Ack and read data are both taken at the edge that ends the wait
    q = wb_dat_i;
    if (!wb_ack_i) hung = 1'b1;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    // Released address and data lines never keep the old value; we and sel do
    wb_adr_o <= ~a;
    wb_dat_o <= ~d;
    @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// [test/tb_multiply_accumulate_unit.sv]
// Self-checking bench for the MAC unit
`timescale 1ns/1ps
`default_nettype none
`include "mac_cfg.svh"
module tb_multiply_accumulate_unit;
  // ----------------------------------------------------------------
  // Signals and reference model state
  // ----------------------------------------------------------------
  logic clk_sys, rst_b, cyc, stb, we, ack, irq;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dw, dr;
  int err_count = 0, comparisons = 0, cyc_cnt = 0;
  logic [15:0] c = 16'h0, a = 16'h0, b = 16'h0;
  logic [47:0] acc = 48'h0;
  logic [1:0] st = 2'h0, mk = 2'h0;
  logic ovf = 1'b0, sa = 1'b0, sb = 1'b0;
  mac_top uut (.clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .irq_o(irq));
  mac_cpu_model cpu (.clk_sys(clk_sys), .wb_cyc_o(cyc), .wb_stb_o(stb),
    .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dw),
    .wb_ack_i(ack), .wb_dat_i(dr));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  function automatic logic [15:0] mg(input logic [15:0] o,
    input logic [15:0] n, input logic [3:0] s);
    return {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
  endfunction
  task automatic run();
    longint p;
    logic v;
    p = c[0] ? longint'($signed(a)) * longint'($signed(b))
      : longint'(a) * longint'(b);
    if (c[2]) p = -p;
    if (c[1]) p = p + (c[0] ? longint'($signed(acc))
      : longint'(acc));
    v = c[0] ? (p < -(64'sh1 <<< 47) || p >= (64'sh1 <<< 47))
      : (p < 0 || p >= (64'sh1 <<< 48));
    sa = 1'b0;
    sb = 1'b0;
    ovf = v;
    st = st | {v, 1'b1};
    if (!c[6]) acc = p[47:0];
  endtask
  task automatic mdl_wr(input logic [2:0] i, input logic [15:0] d,
    input logic [3:0] s);
    case (i)
      3'h0: begin
        c = mg(c, d, s) & 16'h015f;
        if (s[0] && d[5]) {a, b, acc, ovf, sa, sb} = '0;
      end
      3'h1: begin
        a = mg(a, d, s);
        if (c[4]) b = a;
        if (c[4] || c[3] || sb) run();
        else sa = 1'b1;
      end
      3'h2: begin
        b = mg(b, d, s);
        if (c[4]) a = b;
        if (c[4] || c[3] || sa) run();
        else sb = 1'b1;
      end
      3'h3: acc[47:32] = mg(acc[47:32], d, s);
      3'h4: acc[31:16] = mg(acc[31:16], d, s);
      3'h5: acc[15:0] = mg(acc[15:0], d, s);
      3'h6: if (s[0]) st = st & ~d[1:0];
      default: if (s[0]) mk = d[1:0];
    endcase
  endtask
  function automatic logic [31:0] mdl_rd(input logic [2:0] i);
    case (i)
      3'h0: return {16'h0, c[15:8], ovf, c[6:0]};
      3'h1: return {16'h0, a};
      3'h2: return {16'h0, b};
      3'h3: return {16'h0, acc[47:32]};
      3'h4: return {16'h0, acc[31:16]};
      3'h5: return {16'h0, acc[15:0]};
      3'h6: return {30'h0, st};
      default: return {30'h0, mk};
    endcase
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic ok_adr(input logic [7:0] ad);
    return ad[1:0] == 2'h0 && ad[7:5] == 3'h0;
  endfunction
  task automatic bw(input logic [7:0] ad, input logic [15:0] d,
    input logic [3:0] s);
    logic [31:0] q;
    cpu.xfer(1'b1, ad, {16'h0, d}, s, q);
    if (ok_adr(ad)) mdl_wr(ad[4:2], d, s);
  endtask
  task automatic br(input logic [7:0] ad);
    logic [31:0] q;
    cpu.xfer(1'b0, ad, 32'h0, 4'hf, q);
    check(q, ok_adr(ad) ? mdl_rd(ad[4:2]) : 32'h0);
    check({31'h0, irq}, {31'h0, |(st & mk)});
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Ceiling well above the roughly 2500 cycles the run needs
  always @(posedge clk_sys) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_count++;
      conclude();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r, r2;
    logic [15:0] cw;
    int i, j;
    rst_b = 1'b0;
    void'($urandom(32'hd1ff));
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    for (j = 0; j < 8; j++) br({3'h0, j[2:0], 2'h0});
    // Unsigned negate of a nonzero product overflows
    bw(8'h1c, 16'h0003, 4'h1);
    bw(8'h00, 16'h0004, 4'h1);
    bw(8'h04, 16'h0002, 4'h3);
    bw(8'h08, 16'h0003, 4'h3);
    br(8'h00);
    br(8'h18);
    bw(8'h18, 16'h0003, 4'h1);
    br(8'h18);
    for (i = 0; i < 60; i++) begin
      r = $urandom;
      r2 = $urandom;
      cw = r[15:0] & 16'h005f;
      if (r[20:18] == 3'h0) cw[5] = 1'b1;
      bw(8'h00, cw, 4'h3);
      bw(8'h1c, {14'h0, r[17:16]}, 4'h1);
      bw(8'h04, r2[15:0], 4'h3);
      if (r[21]) bw(8'h08, r2[31:16], 4'h3);
      if (r[22]) bw(8'h18, {14'h0, r[24:23]}, r[25] ? 4'h1 : 4'h2);
      if (r[26]) bw(r[27] ? 8'h0c : 8'h14, r2[31:16], r[31:28]);
      if (r[29]) bw(8'h20 + {2'h0, r2[5:0]}, r2[15:0], 4'h3);
      if (r[30]) br(8'h20 + {2'h0, r2[5:0]});
      for (j = 0; j < 8; j++) br({3'h0, j[2:0], 2'h0});
    end
    check({31'h0, cpu.hung}, 32'h0);
    conclude();
  end
endmodule
bind mac_top mac_top_asserts chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
`default_nettype wire
